//--- core/wic_pkg.sv
// constants and helpers for the wake and interrupt control register block
package wic_pkg;

  // ----------------------------------------------------------------
  // serial frame and register layout
  // ----------------------------------------------------------------
  localparam int          FRAME_LEN     = 16;
  localparam logic [2:0]  REG_ADDR      = 3'h2;       // register_select_bits value
  localparam int          SEL_HI        = 15;
  localparam int          SEL_LO        = 13;
  localparam int          WP_BIT        = 12;         // write_protect_flag
  localparam int          MAIN_UV_BIT   = 11;
  localparam int          XCVR_UV_BIT   = 10;
  localparam int          LIN_STBY_BIT  = 9;
  localparam int          RSVD_BIT      = 8;
  localparam int          W1_HI         = 7;
  localparam int          W1_LO         = 6;
  localparam int          W2_HI         = 5;
  localparam int          W2_LO         = 4;
  localparam int          CAN_STBY_BIT  = 3;
  localparam logic [15:0] CTRL_RST      = 16'h0000;   // power-on default of stored bits
  localparam logic [15:0] CTRL_WR_MASK  = 16'h0EF8;   // writable bits only
  localparam logic [4:0]  CNT_MAX       = 5'h11;      // bit counter saturation

  // ----------------------------------------------------------------
  // chip mode and edge selection codes
  // ----------------------------------------------------------------
  localparam int          MODE_NORMAL_BIT = 1;        // leading 1 of chip_mode_field
  localparam int          MODE_REG_BIT    = 0;        // transceiver_regulator on
  localparam logic [1:0]  EDGE_OFF        = 2'h0;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_FALL       = 2'h2;
  localparam logic [1:0]  EDGE_BOTH       = 2'h3;

  typedef enum logic [1:0] {
    XCVR_OFF    = 2'b00,
    XCVR_LOWPWR = 2'b01,
    XCVR_ACTIVE = 2'b10
  } wic_xcvr_mode_t;

  // transceiver mode from its standby bit and the chip mode
  function automatic wic_xcvr_mode_t wic_xcvr_mode(input logic standby, input logic normal);
    if (standby) begin
      wic_xcvr_mode = XCVR_LOWPWR;
    end else if (normal) begin
      wic_xcvr_mode = XCVR_ACTIVE;
    end else begin
      wic_xcvr_mode = XCVR_OFF;
    end
  endfunction : wic_xcvr_mode

endpackage : wic_pkg

//--- core/wic_wake_if.sv
// link between the control register and one local wake edge detector
`timescale 1ns/1ps
`default_nettype none
interface wic_wake_if;
  logic [1:0] edge_sel;
  logic       level;
  logic       hit;

  modport ctl (output edge_sel, output level, input  hit);
  modport det (input  edge_sel, input  level, output hit);
endinterface : wic_wake_if
`default_nettype wire

//--- core/wic_wake_edge.sv
// edge detector for one local wake input
`timescale 1ns/1ps
`default_nettype none
module wic_wake_edge
  import wic_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  wic_wake_if.det    wk
);

  logic prev_q, prev_d;
  logic seen_q, seen_d;
  logic hit_q,  hit_d;

  // ----------------------------------------------------------------
  // edge selection
  // ----------------------------------------------------------------
  // no edge before the first sample, so reset never fakes a wake
  always_comb begin
    prev_d = wk.level;
    seen_d = 1'b1;
    hit_d  = 1'b0;
    if (seen_q) begin
      unique case (wk.edge_sel)
        EDGE_OFF:  hit_d = 1'b0;
        EDGE_RISE: hit_d = wk.level & ~prev_q;
        EDGE_FALL: hit_d = ~wk.level & prev_q;
        EDGE_BOTH: hit_d = wk.level ^ prev_q;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
      hit_q  <= 1'b0;
    end else if (ce) begin
      prev_q <= prev_d;
      seen_q <= seen_d;
      hit_q  <= hit_d;
    end
  end

  assign wk.hit = hit_q;

endmodule : wic_wake_edge
`default_nettype wire

//--- core/wic_ctrl_reg.sv
// interrupt and standby control register with its serial port and decode
//
// What this block does
// R1: bit 12 of a frame set means read only; clear allows the write.
// R2: bit 11 gates main regulator undervoltage warning interrupts.
// R3: bit 10 gates transceiver regulator undervoltage warning interrupts.
// R4: LIN standby 0 in Normal mode: LIN active, its wake flag cleared.
// R5: LIN standby 0 in Standby/Sleep: LIN off, no wake detect or interrupt.
// R6: LIN standby 1: LIN low power, wake detect on, wake interrupts allowed.
// R7: bits 7:6 pick wake input 1 edge: off, rising, falling, both.
// R8: bits 5:4 pick wake input 2 edge: off, rising, falling, both.
// R9: CAN standby 0 in Normal mode: CAN active, its wake flag cleared.
// R10: CAN standby 0 in Standby/Sleep: CAN off, no wake detect or interrupt.
// R11: CAN standby 1: CAN low power, wake detect on, wake interrupts allowed.
// R12: chip mode high bit means Normal; in Normal the low bit switches transceiver regulator.
// R13: host clears pending interrupts by writing 1 in the status register; this block has none, its requests are not latched.
// R14: reserved bits read zero and ignore writes; bit 8 and bits 2:0 are the reserved ones.
`timescale 1ns/1ps
`default_nettype none
module wic_ctrl_reg
  import wic_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  input  wire logic       SCSN_N,
  input  wire logic       SCK,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE,
  input  wire logic [1:0] CHIP_MODE,
  input  wire logic       MAIN_UV_WARN,
  input  wire logic       XCVR_UV_WARN,
  input  wire logic       LIN_BUS_WAKE,
  input  wire logic       CAN_BUS_WAKE,
  input  wire logic       WAKE1,
  input  wire logic       WAKE2,
  output logic            MAIN_UV_IRQ,
  output logic            XCVR_UV_IRQ,
  output logic            LIN_WAKE_IRQ,
  output logic            CAN_WAKE_IRQ,
  output logic            WAKE1_IRQ,
  output logic            WAKE2_IRQ,
  output logic [1:0]      LIN_MODE,
  output logic [1:0]      CAN_MODE,
  output logic            LIN_WAKE_DET_EN,
  output logic            CAN_WAKE_DET_EN,
  output logic            LIN_WAKE_FLAG_CLR,
  output logic            CAN_WAKE_FLAG_CLR,
  output logic            XCVR_REG_ON,
  output logic [15:0]     CTRL_WORD
);

  // ----------------------------------------------------------------
  // serial port state
  // ----------------------------------------------------------------
  logic        sck_q,   sck_d;
  logic        csn_q,   csn_d;
  logic [15:0] rx_q,    rx_d;
  logic [15:0] tx_q,    tx_d;
  logic [4:0]  cnt_q,   cnt_d;
  logic        sdo_q,   sdo_d;
  logic        oe_q,    oe_d;
  logic [15:0] ctrl_q,  ctrl_d;
  logic [15:0] rd_word;

  // read image: select bits, access status zero, reserved bits zero
  assign rd_word = {REG_ADDR, 1'b0, ctrl_q[11:0] & CTRL_WR_MASK[11:0]};  // [R14]

  // frame shift, bit count and end-of-frame write
  always_comb begin
    sck_d  = SCK;
    csn_d  = SCSN_N;
    rx_d   = rx_q;
    tx_d   = tx_q;
    cnt_d  = cnt_q;
    sdo_d  = sdo_q;
    oe_d   = oe_q;
    ctrl_d = ctrl_q;
    if (csn_q && !SCSN_N) begin
      cnt_d = 5'h00;                                   // frame opens
      tx_d  = rd_word;
      sdo_d = rd_word[15];
      oe_d  = 1'b1;
    end else if (!csn_q && SCSN_N) begin
      oe_d  = 1'b0;                                    // frame closes
      sdo_d = 1'b0;
      if (cnt_q == 5'(FRAME_LEN) && rx_q[SEL_HI:SEL_LO] == REG_ADDR
          && !rx_q[WP_BIT]) begin                      // [R1]
        ctrl_d = rx_q & CTRL_WR_MASK;                  // [R14]
      end
    end else if (!SCSN_N) begin
      if (SCK && !sck_q) begin
        rx_d = {rx_q[14:0], SDI};
        if (cnt_q != CNT_MAX) begin
          cnt_d = cnt_q + 5'h01;
        end
      end else if (!SCK && sck_q) begin
        tx_d  = {tx_q[14:0], 1'b0};
        sdo_d = tx_q[14];
      end
    end
  end

  // serial port and register flops
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sck_q  <= 1'b0;
      csn_q  <= 1'b1;
      rx_q   <= 16'h0000;
      tx_q   <= 16'h0000;
      cnt_q  <= 5'h00;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
      ctrl_q <= CTRL_RST;
    end else if (CE) begin
      sck_q  <= sck_d;
      csn_q  <= csn_d;
      rx_q   <= rx_d;
      tx_q   <= tx_d;
      cnt_q  <= cnt_d;
      sdo_q  <= sdo_d;
      oe_q   <= oe_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // local wake edge detectors
  // ----------------------------------------------------------------
  wic_wake_if wk1 ();
  wic_wake_if wk2 ();

  // wake inputs and their edge selections
  assign wk1.edge_sel = ctrl_q[W1_HI:W1_LO];                       // [R7]
  assign wk1.level    = WAKE1;
  assign wk2.edge_sel = ctrl_q[W2_HI:W2_LO];                       // [R8]
  assign wk2.level    = WAKE2;

  wic_wake_edge u_wake1 (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .wk    (wk1.det)
  );

  wic_wake_edge u_wake2 (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .wk    (wk2.det)
  );

  // ----------------------------------------------------------------
  // mode decode and interrupt requests
  // ----------------------------------------------------------------
  wic_xcvr_mode_t lin_mode_q, lin_mode_d;
  wic_xcvr_mode_t can_mode_q, can_mode_d;
  logic           normal;
  logic [5:0]     irq_q, irq_d;
  logic [4:0]     ctl_q, ctl_d;

  assign normal = CHIP_MODE[MODE_NORMAL_BIT];                       // [R12]

  // transceiver modes, wake detect, flag clears and gated requests
  always_comb begin
    lin_mode_d = wic_xcvr_mode(ctrl_q[LIN_STBY_BIT], normal);      // [R4] [R5] [R6]
    can_mode_d = wic_xcvr_mode(ctrl_q[CAN_STBY_BIT], normal);      // [R9] [R10] [R11]
    ctl_d[0]   = ctrl_q[LIN_STBY_BIT];                             // [R5] [R6]
    ctl_d[1]   = ctrl_q[CAN_STBY_BIT];                             // [R10] [R11]
    ctl_d[2]   = !ctrl_q[LIN_STBY_BIT] && normal;                  // [R4]
    ctl_d[3]   = !ctrl_q[CAN_STBY_BIT] && normal;                  // [R9]
    ctl_d[4]   = normal && CHIP_MODE[MODE_REG_BIT];                // [R12]
    irq_d[0]   = MAIN_UV_WARN && ctrl_q[MAIN_UV_BIT];              // [R2]
    irq_d[1]   = XCVR_UV_WARN && ctrl_q[XCVR_UV_BIT];              // [R3]
    irq_d[2]   = LIN_BUS_WAKE && ctrl_q[LIN_STBY_BIT];             // [R5] [R6]
    irq_d[3]   = CAN_BUS_WAKE && ctrl_q[CAN_STBY_BIT];             // [R10] [R11]
    irq_d[4]   = wk1.hit;                                          // [R7]
    irq_d[5]   = wk2.hit;                                          // [R8]
  end

  // decode and request flops
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      lin_mode_q <= XCVR_OFF;
      can_mode_q <= XCVR_OFF;
      ctl_q      <= 5'h00;
      irq_q      <= 6'h00;
    end else if (CE) begin
      lin_mode_q <= lin_mode_d;
      can_mode_q <= can_mode_d;
      ctl_q      <= ctl_d;
      irq_q      <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign SDO               = sdo_q;
  assign SDO_OE            = oe_q;
  assign MAIN_UV_IRQ       = irq_q[0];
  assign XCVR_UV_IRQ       = irq_q[1];
  assign LIN_WAKE_IRQ      = irq_q[2];
  assign CAN_WAKE_IRQ      = irq_q[3];
  assign WAKE1_IRQ         = irq_q[4];
  assign WAKE2_IRQ         = irq_q[5];
  assign LIN_MODE          = lin_mode_q;
  assign CAN_MODE          = can_mode_q;
  assign LIN_WAKE_DET_EN   = ctl_q[0];
  assign CAN_WAKE_DET_EN   = ctl_q[1];
  assign LIN_WAKE_FLAG_CLR = ctl_q[2];
  assign CAN_WAKE_FLAG_CLR = ctl_q[3];
  assign XCVR_REG_ON       = ctl_q[4];
  assign CTRL_WORD         = ctrl_q;

endmodule : wic_ctrl_reg
`default_nettype wire

//--- testbench/wic_ctrl_reg_props.sv
// port assertions for the interrupt and standby control register
`timescale 1ns/1ps
`default_nettype none
module wic_ctrl_reg_props
  import wic_pkg::*;
(
  input wire logic        REF_CLK, RST_N, SCSN_N, WAKE1, WAKE2, MAIN_UV_WARN, XCVR_UV_WARN,
  input wire logic        LIN_BUS_WAKE, CAN_BUS_WAKE, MAIN_UV_IRQ, XCVR_UV_IRQ, LIN_WAKE_IRQ,
  input wire logic        CAN_WAKE_IRQ, WAKE1_IRQ, WAKE2_IRQ, LIN_WAKE_DET_EN, CAN_WAKE_DET_EN,
  input wire logic        LIN_WAKE_FLAG_CLR, CAN_WAKE_FLAG_CLR, XCVR_REG_ON, SDO_OE,
  input wire logic [1:0]  CHIP_MODE, LIN_MODE, CAN_MODE,
  input wire logic [15:0] CTRL_WORD
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] up_q;
  // history of reset release, one bit per past edge
  always_ff @(posedge REF_CLK) up_q <= {up_q[2:0], RST_N};

  property p_main_uv; &up_q[1:0] |-> MAIN_UV_IRQ == $past(MAIN_UV_WARN && CTRL_WORD[11]); endproperty
  a_main_uv: assert property (p_main_uv) else $error("main uv request wrong");
  property p_xcvr_uv; &up_q[1:0] |-> XCVR_UV_IRQ == $past(XCVR_UV_WARN && CTRL_WORD[10]); endproperty
  a_xcvr_uv: assert property (p_xcvr_uv) else $error("xcvr uv request wrong");
  property p_lin; &up_q[1:0] |-> {LIN_WAKE_IRQ, LIN_WAKE_FLAG_CLR, LIN_WAKE_DET_EN, LIN_MODE}
    == {$past(LIN_BUS_WAKE && CTRL_WORD[9]), $past(!CTRL_WORD[9] && CHIP_MODE[1]),
    $past(CTRL_WORD[9]), $past(!CTRL_WORD[9] && CHIP_MODE[1]), $past(CTRL_WORD[9])}; endproperty
  a_lin: assert property (p_lin) else $error("lin decode wrong");
  property p_can; &up_q[1:0] |-> {CAN_WAKE_IRQ, CAN_WAKE_FLAG_CLR, CAN_WAKE_DET_EN, CAN_MODE}
    == {$past(CAN_BUS_WAKE && CTRL_WORD[3]), $past(!CTRL_WORD[3] && CHIP_MODE[1]),
    $past(CTRL_WORD[3]), $past(!CTRL_WORD[3] && CHIP_MODE[1]), $past(CTRL_WORD[3])}; endproperty
  a_can: assert property (p_can) else $error("can decode wrong");
  property p_xreg; &up_q[1:0] |-> XCVR_REG_ON == $past(CHIP_MODE == 2'h3); endproperty
  a_xreg: assert property (p_xreg) else $error("regulator enable wrong");
  property p_wake1; &up_q |-> WAKE1_IRQ == (($past(WAKE1,2) && !$past(WAKE1,3)
    && $past(CTRL_WORD[6],2)) || (!$past(WAKE1,2) && $past(WAKE1,3) && $past(CTRL_WORD[7],2)));
  endproperty
  a_wake1: assert property (p_wake1) else $error("wake 1 pulse wrong");
  property p_wake2; &up_q |-> WAKE2_IRQ == (($past(WAKE2,2) && !$past(WAKE2,3)
    && $past(CTRL_WORD[4],2)) || (!$past(WAKE2,2) && $past(WAKE2,3) && $past(CTRL_WORD[5],2)));
  endproperty
  a_wake2: assert property (p_wake2) else $error("wake 2 pulse wrong");
  property p_hold; &up_q[1:0] && !($past(SCSN_N) && !$past(SCSN_N,2)) |-> $stable(CTRL_WORD);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed outside frame");
  property p_oe; up_q[0] |-> SDO_OE == !$past(SCSN_N); endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_rsvd; (CTRL_WORD & ~CTRL_WR_MASK) == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule : wic_ctrl_reg_props
`default_nettype wire

//--- testbench/wic_host_model.sv
// host side of the serial control port
`timescale 1ns/1ps
`default_nettype none
module wic_host_model (
  input  wire logic REF_CLK,
  input  wire logic SDO,
  output var logic  SCSN_N,
  output var logic  SCK,
  output var logic  SDI
);
  // idle: deselected, clock low
  initial begin
    SCSN_N = 1'b1;
    SCK    = 1'b0;
    SDI    = 1'b0;
  end
  // n edges, then launch just after the edge
  task automatic hold(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : hold
  // one frame, msb first; only control frames, status clears are not sent
  task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    SCSN_N = 1'b0;
    hold(3);
    for (int i = 0; i < n; i++) begin
      SCK = 1'b0;
      SDI = w[15 - i];
      hold(3);
      r = {r[14:0], SDO};  // read bit settled while clock low
      SCK = 1'b1;
      hold(3);
    end
    SCK = 1'b0;
    hold(3);
    SCSN_N = 1'b1;
    SDI = ~SDI;  // released line does not keep its value
    hold(3);
  endtask : xfer
endmodule : wic_host_model
`default_nettype wire

//--- testbench/wic_ctrl_reg_tb_top.sv
// self-checking bench for the control register
`timescale 1ns/1ps
`default_nettype none
module wic_ctrl_reg_tb_top
  import wic_pkg::*;
;
  logic        REF_CLK, RST_N, CE, SCSN_N, SCK, SDI, SDO, SDO_OE, XCVR_REG_ON;
  logic        MAIN_UV_WARN, XCVR_UV_WARN, LIN_BUS_WAKE, CAN_BUS_WAKE, WAKE1, WAKE2;
  logic        MAIN_UV_IRQ, XCVR_UV_IRQ, LIN_WAKE_IRQ, CAN_WAKE_IRQ, WAKE1_IRQ, WAKE2_IRQ;
  logic        LIN_WAKE_DET_EN, CAN_WAKE_DET_EN, LIN_WAKE_FLAG_CLR, CAN_WAKE_FLAG_CLR;
  logic [1:0]  CHIP_MODE, LIN_MODE, CAN_MODE, m2;
  logic [15:0] CTRL_WORD, rd;
  int          miscompares, check_count, cycles, p1, p2;

  wic_ctrl_reg   DUT (.*);
  wic_host_model HOST (.REF_CLK(REF_CLK), .SDO(SDO), .SCSN_N(SCSN_N), .SCK(SCK), .SDI(SDI));

  // clock, timeout and wake pulse counting
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cycles++;
    p1 += int'(WAKE1_IRQ === 1'b1);
    p2 += int'(WAKE2_IRQ === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // reset value, read-only frames, refused frames, reserved bits
  task automatic t_access;
    chk("reset word", 16'h0000, CTRL_WORD);
    HOST.xfer(16, 16'h5FFF, rd);
    chk("read image", 16'h4000, rd);
    chk("read only kept", 16'h0000, CTRL_WORD);
    HOST.xfer(16, 16'h6FFF, rd);
    HOST.xfer(15, 16'h4FFF, rd);
    chk("refused kept", 16'h0000, CTRL_WORD);
    HOST.xfer(16, 16'h4FFF, rd);
    chk("masked write", 16'h0EF8, CTRL_WORD);
    HOST.xfer(16, 16'h5000, rd);
    chk("read back", 16'h4EF8, rd);
  endtask : t_access

  // standby bits against every chip mode
  task automatic t_modes;
    LIN_BUS_WAKE = 1'b1;
    CAN_BUS_WAKE = 1'b1;
    for (int s = 0; s < 2; s++) begin
      HOST.xfer(16, {6'h10, s[0], 5'h00, s[0], 3'h0}, rd);
      for (int m = 0; m < 4; m++) begin
        CHIP_MODE = m[1:0];
        step(3);
        m2 = s[0] ? 2'h1 : (m[1] ? 2'h2 : 2'h0);
        chk("lin", {10'h0, s[0], !s[0] && m[1], s[0], m2, 1'b0}, {10'h0, LIN_WAKE_IRQ,
          LIN_WAKE_FLAG_CLR, LIN_WAKE_DET_EN, LIN_MODE, 1'b0});
        chk("can", {10'h0, s[0], !s[0] && m[1], s[0], m2, m == 3}, {10'h0, CAN_WAKE_IRQ,
          CAN_WAKE_FLAG_CLR, CAN_WAKE_DET_EN, CAN_MODE, XCVR_REG_ON});
      end
    end
  endtask : t_modes

  // undervoltage gates, each enable combination
  task automatic t_irq;
    MAIN_UV_WARN = 1'b1;
    XCVR_UV_WARN = 1'b1;
    for (int e = 0; e < 4; e++) begin
      HOST.xfer(16, {4'h4, e[1:0], 10'h000}, rd);
      chk("uv irq", {14'h0, e[1:0]}, {14'h0, MAIN_UV_IRQ, XCVR_UV_IRQ});
    end
    MAIN_UV_WARN = 1'b0;
    step(2);
    chk("uv irq quiet", 16'h0001, {14'h0, MAIN_UV_IRQ, XCVR_UV_IRQ});
  endtask : t_irq

  // every edge code on both wake inputs
  task automatic t_wake;
    for (int c = 0; c < 4; c++) begin
      HOST.xfer(16, {8'h40, c[1:0], ~c[1:0], 4'h0}, rd);
      p1 = 0;
      p2 = 0;
      WAKE1 = 1'b1;
      WAKE2 = 1'b1;
      step(6);
      chk("wake1 rise pulses", 16'(c % 2), 16'(p1));
      chk("wake2 rise pulses", 16'((3 - c) % 2), 16'(p2));
      WAKE1 = 1'b0;
      WAKE2 = 1'b0;
      step(6);
      chk("wake1 pulses", 16'(c % 2 + c / 2), 16'(p1));
      chk("wake2 pulses", 16'((3 - c) % 2 + (3 - c) / 2), 16'(p2));
    end
  endtask : t_wake

  // reset in mid-run clears the word and the decode
  task automatic t_reset;
    CHIP_MODE = 2'h3;
    HOST.xfer(16, 16'h4208, rd);
    chk("both standby set", 16'h0208, CTRL_WORD);
    RST_N = 1'b0;
    step(2);
    chk("mid reset word", 16'h0000, CTRL_WORD);
    chk("mid reset decode", 16'h0000, {10'h0, LIN_MODE, CAN_MODE, XCVR_REG_ON,
      LIN_WAKE_IRQ});
    RST_N = 1'b1;
    step(2);
    chk("after reset decode", {10'h0, 2'h2, 2'h2, 1'b1, 1'b0}, {10'h0, LIN_MODE, CAN_MODE,
      XCVR_REG_ON, LIN_WAKE_IRQ});
  endtask : t_reset

  // main sequence
  initial begin
    {RST_N, CHIP_MODE, MAIN_UV_WARN, XCVR_UV_WARN, LIN_BUS_WAKE, CAN_BUS_WAKE} = '0;
    {WAKE1, WAKE2, miscompares, check_count, cycles, p1, p2} = '0;
    CE = 1'b1;
    step(4);
    RST_N = 1'b1;
    step(2);
    t_access();
    t_modes();
    t_irq();
    t_wake();
    t_reset();
    give_verdict();
  end
endmodule : wic_ctrl_reg_tb_top

bind wic_ctrl_reg wic_ctrl_reg_props u_props (.*);
`default_nettype wire
